// file: src/frc_fan_ramp.sv
// Fan duty ramp limiter with thermal-alert operating point capture, APB slave.
// Assumes all inputs are synchronous to clk_sys and the APB master follows AMBA APB.
`timescale 1ns/10ps
module frc_fan_ramp #(
  parameter int TICK_CYCLES = frc_pkg::TICK_CYCLES
) (
  input  wire logic              clk_sys,
  input  wire logic              nrst,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [11:0]       paddr,
  input  wire logic [31:0]       pwdata,
  output logic [31:0]            prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic              thermal_alert_n,
  input  wire frc_pkg::frc_chan_s cur_temp,
  input  wire frc_pkg::frc_chan_s adj_start_temp,
  input  wire logic              adj_start_valid,
  input  wire frc_pkg::frc_duty_s duty_target,
  output frc_pkg::frc_duty_s     duty_out,
  output frc_pkg::frc_chan_s     fan_start_temp,
  output frc_pkg::frc_chan_s     op_point,
  output logic [2:0]             dyn_floor_en
);
  import frc_pkg::*;

  logic [7:0]  dyn_ctrl_reg;
  logic [7:0]  cfg_reg    [NUM_CH];
  logic [7:0]  ramp1_reg;
  logic [7:0]  ramp2_reg;
  logic [7:0]  oppt_reg   [NUM_CH];
  logic [7:0]  start_reg  [NUM_CH];
  logic [7:0]  duty_reg   [NUM_CH];
  logic [1:0]  slow_cnt_reg [NUM_CH];
  logic        alert_prev_reg;
  logic        alert_event;
  logic [31:0] tick_cnt_reg;
  logic        tick;
  logic [31:0] rdata_reg;
  logic        err_reg;
  logic        wr_en;
  logic [7:0]  widx;
  logic [7:0]  temp_ch    [NUM_CH];
  logic [7:0]  tgt_ch     [NUM_CH];
  logic [7:0]  adj_ch     [NUM_CH];
  logic        remote2_alert_capture_en;
  logic        local_alert_capture_en;
  logic        remote1_alert_capture_en;
  logic        remote2_dynamic_floor_en;
  logic        local_dynamic_floor_en;
  logic        remote1_dynamic_floor_en;
  logic [2:0]  ramp_code_out1;
  logic [2:0]  ramp_code_out2;
  logic [2:0]  ramp_code_out3;
  logic        cap_en_ch  [NUM_CH];
  logic        dyn_en_ch  [NUM_CH];
  logic [2:0]  code_ch    [NUM_CH];
  logic        ramp_code_out1_ch    [NUM_CH];
  logic        slow_ch    [NUM_CH];
  logic [7:0]  step_ch    [NUM_CH];
  logic        step_now_ch [NUM_CH];
  logic [7:0]  duty_next  [NUM_CH];

  // Step size in duty slots for a three-bit ramp code.
  function automatic logic [7:0] step_of(input logic [2:0] code);
    case (code)
      3'd0:    step_of = 8'h01;
      3'd1:    step_of = 8'h02;
      3'd2:    step_of = 8'h03;
      3'd3:    step_of = 8'h05;
      3'd4:    step_of = 8'h08;
      3'd5:    step_of = 8'h0c;
      3'd6:    step_of = 8'h18;
      default: step_of = 8'h30;
    endcase
  endfunction

  // Ramp code of one fan output.
  function automatic logic [2:0] code_of(input int ch, input logic [7:0] r1,
                                         input logic [7:0] r2);
    case (ch)
      0:       code_of = r1[CODE_LO_LSB +: 3];
      1:       code_of = r2[CODE_HI_LSB +: 3];
      default: code_of = r2[CODE_LO_LSB +: 3];
    endcase
  endfunction

  // Acoustic enable of one fan output.
  function automatic logic ramp_code_out1_en(input int ch, input logic [7:0] r1,
                                   input logic [7:0] r2);
    case (ch)
      0:       ramp_code_out1_en = r1[EN_LO_BIT];
      1:       ramp_code_out1_en = r2[EN_HI_BIT];
      default: ramp_code_out1_en = r2[EN_LO_BIT];
    endcase
  endfunction

  // Next ramped duty: one step toward target, landing exactly when close.
  function automatic logic [7:0] ramp_next(input logic [7:0] prev,
                                           input logic [7:0] tgt,
                                           input logic [7:0] step);
    if (tgt > prev) begin
      if (tgt - prev < step) begin
        ramp_next = tgt;
      end else begin
        ramp_next = prev + step;
      end
    end else if (tgt < prev) begin
      if (prev - tgt < step) begin
        ramp_next = tgt;
      end else begin
        ramp_next = prev - step;
      end
    end else begin
      ramp_next = prev;
    end
  endfunction

  assign temp_ch[0] = cur_temp.remote1;
  assign temp_ch[1] = cur_temp.local_t;
  assign temp_ch[2] = cur_temp.remote2;
  assign adj_ch[0]  = adj_start_temp.remote1;
  assign adj_ch[1]  = adj_start_temp.local_t;
  assign adj_ch[2]  = adj_start_temp.remote2;
  assign tgt_ch[0]  = duty_target.out1;
  assign tgt_ch[1]  = duty_target.out2;
  assign tgt_ch[2]  = duty_target.out3;

  // Control fields, one signal per field.
  // Capture and dynamic bits keep their register positions.
  assign remote2_alert_capture_en = dyn_ctrl_reg[CAP_R2_BIT];
  assign local_alert_capture_en   = dyn_ctrl_reg[CAP_LOC_BIT];
  assign remote1_alert_capture_en = dyn_ctrl_reg[CAP_R1_BIT];
  assign remote2_dynamic_floor_en = dyn_ctrl_reg[DYN_R2_BIT];
  assign local_dynamic_floor_en   = dyn_ctrl_reg[DYN_LOC_BIT];
  assign remote1_dynamic_floor_en = dyn_ctrl_reg[DYN_R1_BIT];
  assign ramp_code_out1           = code_of(0, ramp1_reg, ramp2_reg);
  assign ramp_code_out2           = code_of(1, ramp1_reg, ramp2_reg);
  assign ramp_code_out3           = code_of(2, ramp1_reg, ramp2_reg);

  // Per-channel views: index 0 is remote 1 or output 1, index 2 remote 2 or output 3.
  assign cap_en_ch[0] = remote1_alert_capture_en;
  assign cap_en_ch[1] = local_alert_capture_en;
  assign cap_en_ch[2] = remote2_alert_capture_en;
  assign dyn_en_ch[0] = remote1_dynamic_floor_en;
  assign dyn_en_ch[1] = local_dynamic_floor_en;
  assign dyn_en_ch[2] = remote2_dynamic_floor_en;
  assign code_ch[0]   = ramp_code_out1;
  assign code_ch[1]   = ramp_code_out2;
  assign code_ch[2]   = ramp_code_out3;
  assign slow_ch[0]   = cfg_reg[0][SLOW_BIT];
  assign slow_ch[1]   = cfg_reg[1][SLOW_BIT];
  assign slow_ch[2]   = cfg_reg[2][SLOW_BIT];

  // APB: zero-wait access; read data is captured in the setup cycle.
  assign pready  = psel & penable;
  assign pslverr = psel & penable & err_reg;
  assign prdata  = rdata_reg;
  assign wr_en   = psel & penable & pwrite & ~err_reg;
  assign widx    = paddr[9:2];

  // Unmapped or misaligned addresses answer with an error.
  function automatic logic mapped(input logic [11:0] a);
    logic [7:0] i;
    logic       aligned;
    logic       ctrl_hit;
    logic       cfg_hit;
    logic       ramp_hit;
    logic       bank_hit;
    i        = a[9:2];
    aligned  = (a[1:0] == 2'b00) && (a[11:10] == 2'b00);
    ctrl_hit = (i == IDX_DYN_CTRL);
    cfg_hit  = (i >= IDX_OUT1_CFG) && (i <= IDX_OUT3_CFG);
    ramp_hit = (i == IDX_RAMP_1) || (i == IDX_RAMP_2);
    bank_hit = (i >= IDX_OPPT_BASE) && (i < IDX_TEMP_BASE + 8'd3) && (i[1:0] != 2'b11);
    mapped   = aligned && (ctrl_hit || cfg_hit || ramp_hit || bank_hit);
  endfunction

  // Read data and the error flag are latched in the setup cycle.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      rdata_reg <= 32'h0000_0000;
      err_reg   <= 1'b0;
    end else if (psel && !penable) begin
      err_reg   <= ~mapped(paddr);
      rdata_reg <= 32'h0000_0000;
      if (!pwrite) begin
        case (widx)
          IDX_DYN_CTRL:          rdata_reg[7:0] <= dyn_ctrl_reg;
          IDX_OUT1_CFG:          rdata_reg[7:0] <= cfg_reg[0];
          IDX_OUT2_CFG:          rdata_reg[7:0] <= cfg_reg[1];
          IDX_OUT3_CFG:          rdata_reg[7:0] <= cfg_reg[2];
          IDX_RAMP_1:            rdata_reg[7:0] <= ramp1_reg;
          IDX_RAMP_2:            rdata_reg[7:0] <= ramp2_reg;
          IDX_OPPT_BASE:         rdata_reg[7:0] <= oppt_reg[0];
          IDX_OPPT_BASE + 8'd1:  rdata_reg[7:0] <= oppt_reg[1];
          IDX_OPPT_BASE + 8'd2:  rdata_reg[7:0] <= oppt_reg[2];
          IDX_START_BASE:        rdata_reg[7:0] <= start_reg[0];
          IDX_START_BASE + 8'd1: rdata_reg[7:0] <= start_reg[1];
          IDX_START_BASE + 8'd2: rdata_reg[7:0] <= start_reg[2];
          IDX_DUTY_BASE:         rdata_reg[7:0] <= duty_reg[0];
          IDX_DUTY_BASE + 8'd1:  rdata_reg[7:0] <= duty_reg[1];
          IDX_DUTY_BASE + 8'd2:  rdata_reg[7:0] <= duty_reg[2];
          IDX_TEMP_BASE:         rdata_reg[7:0] <= temp_ch[0];
          IDX_TEMP_BASE + 8'd1:  rdata_reg[7:0] <= temp_ch[1];
          IDX_TEMP_BASE + 8'd2:  rdata_reg[7:0] <= temp_ch[2];
          default:               rdata_reg <= 32'h0000_0000;
        endcase
      end
    end
  end

  // Control registers written by software.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      dyn_ctrl_reg <= RST_BYTE;
      ramp1_reg    <= RST_BYTE;
      ramp2_reg    <= RST_BYTE;
      cfg_reg[0]   <= RST_BYTE;
      cfg_reg[1]   <= RST_BYTE;
      cfg_reg[2]   <= RST_BYTE;
    end else if (wr_en) begin
      case (widx)
        IDX_DYN_CTRL: dyn_ctrl_reg <= pwdata[7:0];
        IDX_OUT1_CFG: cfg_reg[0]   <= pwdata[7:0];
        IDX_OUT2_CFG: cfg_reg[1]   <= pwdata[7:0];
        IDX_OUT3_CFG: cfg_reg[2]   <= pwdata[7:0];
        IDX_RAMP_1:   ramp1_reg    <= pwdata[7:0];
        IDX_RAMP_2:   ramp2_reg    <= pwdata[7:0];
        default:      ;
      endcase
    end
  end

  // Alert event is the falling edge of the active-low alert input.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      alert_prev_reg <= 1'b1;
    end else begin
      alert_prev_reg <= thermal_alert_n;
    end
  end
  assign alert_event = alert_prev_reg & ~thermal_alert_n;

  // Update tick: one duty update per slot time of a full-scale 35 s ramp.
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else if (tick) begin
      tick_cnt_reg <= 32'h0000_0000;
    end else begin
      tick_cnt_reg <= tick_cnt_reg + 32'h0000_0001;
    end
  end
  assign tick = (tick_cnt_reg == 32'(TICK_CYCLES - 1));

  // Per-channel capture, fan-start and duty logic.
  genvar g;
  generate
    for (g = 0; g < NUM_CH; g++) begin : g_ch
      // Operating point: capture on alert wins over a software write.
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          oppt_reg[g] <= RST_BYTE;
        end else if (alert_event && cap_en_ch[g]) begin
          oppt_reg[g] <= temp_ch[g];
        end else if (wr_en && widx == IDX_OPPT_BASE + 8'(g)) begin
          oppt_reg[g] <= pwdata[7:0];
        end
      end

      // Fan-start temperature: adjusted only while dynamic mode is on.
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          start_reg[g] <= RST_BYTE;
        end else if (adj_start_valid && dyn_en_ch[g]) begin
          start_reg[g] <= adj_ch[g];
        end else if (wr_en && widx == IDX_START_BASE + 8'(g)) begin
          start_reg[g] <= pwdata[7:0];
        end
      end
      assign dyn_floor_en[g] = dyn_en_ch[g];

      // Slowdown counter counts updates; step only on the fourth.
      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          slow_cnt_reg[g] <= 2'b00;
        end else if (tick) begin
          slow_cnt_reg[g] <= slow_cnt_reg[g] + 2'b01;
        end
      end

      assign ramp_code_out1_ch[g]     = ramp_code_out1_en(g, ramp1_reg, ramp2_reg);
      assign step_ch[g]     = step_of(code_ch[g]);
      assign step_now_ch[g] = tick && (!slow_ch[g] || slow_cnt_reg[g] == SLOW_LAST);

      // Duty in 1/255 slots, ramped or direct.
      always_comb begin
        if (!ramp_code_out1_ch[g]) begin
          duty_next[g] = tgt_ch[g];
        end else if (step_now_ch[g]) begin
          duty_next[g] = ramp_next(duty_reg[g], tgt_ch[g], step_ch[g]);
        end else begin
          // Between steps the ramped duty holds its value.
          duty_next[g] = duty_reg[g];
        end
      end

      always_ff @(posedge clk_sys or negedge nrst) begin
        if (!nrst) begin
          duty_reg[g] <= RST_BYTE;
        end else begin
          duty_reg[g] <= duty_next[g];
        end
      end
    end
  endgenerate

  assign duty_out.out1       = duty_reg[0];
  assign duty_out.out2       = duty_reg[1];
  assign duty_out.out3       = duty_reg[2];
  assign fan_start_temp.remote1 = start_reg[0];
  assign fan_start_temp.local_t = start_reg[1];
  assign fan_start_temp.remote2 = start_reg[2];
  assign op_point.remote1    = oppt_reg[0];
  assign op_point.local_t    = oppt_reg[1];
  assign op_point.remote2    = oppt_reg[2];

endmodule // frc_fan_ramp

// file: src/frc_pkg.sv
// Package for the fan ramp limiter and alert-driven operating point capture.
// Assumes a 40 MHz system clock and a 32-bit APB with word-aligned registers.
package frc_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [7:0] IDX_DYN_CTRL   = 8'h36;
  localparam logic [7:0] IDX_OUT1_CFG   = 8'h5c;
  localparam logic [7:0] IDX_OUT2_CFG   = 8'h5d;
  localparam logic [7:0] IDX_OUT3_CFG   = 8'h5e;
  localparam logic [7:0] IDX_RAMP_1     = 8'h62;
  localparam logic [7:0] IDX_RAMP_2     = 8'h63;
  localparam logic [7:0] IDX_OPPT_BASE  = 8'h70;
  localparam logic [7:0] IDX_START_BASE = 8'h74;
  localparam logic [7:0] IDX_DUTY_BASE  = 8'h78;
  localparam logic [7:0] IDX_TEMP_BASE  = 8'h7c;

  // Reset values.
  localparam logic [7:0] RST_BYTE = 8'h00;

  // Field positions.
  localparam int CAP_R2_BIT  = 2;
  localparam int CAP_LOC_BIT = 3;
  localparam int CAP_R1_BIT  = 4;
  localparam int DYN_R2_BIT  = 5;
  localparam int DYN_LOC_BIT = 6;
  localparam int DYN_R1_BIT  = 7;
  localparam int SLOW_BIT    = 3;
  localparam int CODE_LO_LSB = 0;
  localparam int CODE_HI_LSB = 4;
  localparam int EN_LO_BIT   = 3;
  localparam int EN_HI_BIT   = 7;
  localparam int NUM_CH      = 3;

  // Duty scale and ramp timing.
  localparam logic [7:0] DUTY_FULL     = 8'hff;
  localparam int         DUTY_SLOTS    = 255;
  localparam longint     FULL_RAMP_MS  = 35000;
  localparam longint     CLK_PERIOD_PS = 25000;
  localparam longint     TICK_CYCLES_L =
    (FULL_RAMP_MS * 64'd1000000000) / (DUTY_SLOTS * CLK_PERIOD_PS);
  localparam int         TICK_CYCLES   = int'(TICK_CYCLES_L);
  localparam logic [1:0] SLOW_LAST     = 2'h3;

  // One byte per temperature channel: remote 1, local, remote 2.
  typedef struct packed {
    logic [7:0] remote2;
    logic [7:0] local_t;
    logic [7:0] remote1;
  } frc_chan_s;

  // One byte per fan output: output 3, output 2, output 1.
  typedef struct packed {
    logic [7:0] out3;
    logic [7:0] out2;
    logic [7:0] out1;
  } frc_duty_s;

endpackage

// file: dv/frc_cpu_model.sv
// Processor model: drives the thermal alert and the current temperatures.
// Assumes the bench raises hot while the processor is overheating.
`timescale 1ns/10ps
module frc_cpu_model (
  input  wire logic               clk_sys,
  input  wire logic               nrst,
  input  wire logic               hot,
  input  wire frc_pkg::frc_chan_s temp_set,
  output logic                    thermal_alert_n,
  output frc_pkg::frc_chan_s      cur_temp
);
  always_ff @(posedge clk_sys or negedge nrst) begin
    if (!nrst) begin
      thermal_alert_n <= 1'b1;
      cur_temp        <= '0;
    end else begin
      thermal_alert_n <= !hot;
      cur_temp        <= temp_set;
    end
  end
endmodule // frc_cpu_model

// file: dv/frc_fan_ramp_checker.sv
// Checker for the fan ramp block: watches its APB, capture and duty ports.
// Assumes it is bound to every instance of frc_fan_ramp.
`timescale 1ns/10ps
module frc_fan_ramp_checker (
  input wire logic               clk_sys,
  input wire logic               nrst,
  input wire logic               psel,
  input wire logic               penable,
  input wire logic               pwrite,
  input wire logic [31:0]        prdata,
  input wire logic               pready,
  input wire logic               pslverr,
  input wire logic               thermal_alert_n,
  input wire frc_pkg::frc_chan_s adj_start_temp,
  input wire logic               adj_start_valid,
  input wire frc_pkg::frc_duty_s duty_target,
  input wire frc_pkg::frc_duty_s duty_out,
  input wire frc_pkg::frc_chan_s fan_start_temp,
  input wire frc_pkg::frc_chan_s op_point,
  input wire logic [2:0]         dyn_floor_en
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);
  sequence s_acc;
    psel && penable;
  endsequence
  sequence s_fall;
    thermal_alert_n ##1 !thermal_alert_n;
  endsequence
  chk_zero_wait: assert property (s_acc |-> pready)
    else $error("pready low in access");
  chk_err_access: assert property (pslverr |-> psel && penable)
    else $error("pslverr outside access");
  chk_read_upper: assert property (s_acc ##0 !pwrite |-> prdata[31:8] == 24'h00_0000)
    else $error("read upper bits set");
  chk_op_cause: assert property ($changed(op_point) |->
    $past(psel && penable && pwrite) || ($past(thermal_alert_n, 2) && !$past(thermal_alert_n)))
    else $error("operating point changed without cause");
  chk_start_hold: assert property ($changed(fan_start_temp) |->
    $past(adj_start_valid) || $past(psel && penable && pwrite))
    else $error("fan start changed without cause");
  chk_r2_load: assert property (adj_start_valid && dyn_floor_en[2] && !(psel && pwrite)
    |=> fan_start_temp.remote2 == $past(adj_start_temp.remote2))
    else $error("remote2 fan start not loaded");
  chk_loc_load: assert property (adj_start_valid && dyn_floor_en[1] && !(psel && pwrite)
    |=> fan_start_temp.local_t == $past(adj_start_temp.local_t))
    else $error("local fan start not loaded");
  chk_r1_load: assert property (adj_start_valid && dyn_floor_en[0] && !(psel && pwrite)
    |=> fan_start_temp.remote1 == $past(adj_start_temp.remote1))
    else $error("remote1 fan start not loaded");
  chk_up_bound: assert property (duty_out.out1 > $past(duty_out.out1)
    |-> duty_out.out1 <= $past(duty_target.out1))
    else $error("duty rose past target");
  chk_down_bound: assert property (duty_out.out1 < $past(duty_out.out1)
    |-> duty_out.out1 >= $past(duty_target.out1))
    else $error("duty fell past target");
  cover property (s_fall);
endmodule // frc_fan_ramp_checker
bind frc_fan_ramp frc_fan_ramp_checker u_chk (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .thermal_alert_n(thermal_alert_n), .adj_start_temp(adj_start_temp),
  .adj_start_valid(adj_start_valid), .duty_target(duty_target), .duty_out(duty_out),
  .fan_start_temp(fan_start_temp), .op_point(op_point), .dyn_floor_en(dyn_floor_en));

// file: dv/tb_fan_ramp_and_setpoint_capture.sv
// Bench for the fan ramp limiter and alert capture block.
// Assumes the processor model and a shortened update tick of 8 cycles.
`timescale 1ns/10ps
module tb_fan_ramp_and_setpoint_capture;
  import frc_pkg::*;
  localparam int TK = 8;
  logic        clk_sys = 1'b0;
  logic        nrst = 1'b0;
  logic        psel = 1'b0;
  logic        penable = 1'b0;
  logic        pwrite = 1'b0;
  logic [11:0] paddr = '0;
  logic [31:0] pwdata = '0;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        thermal_alert_n;
  logic        hot = 1'b0;
  logic        adj_start_valid = 1'b0;
  logic [2:0]  dyn_floor_en;
  frc_chan_s   temp_set = '0;
  frc_chan_s   cur_temp;
  frc_chan_s   adj_start_temp = '0;
  frc_chan_s   fan_start_temp;
  frc_chan_s   op_point;
  frc_duty_s   duty_target = '0;
  frc_duty_s   duty_out;
  int          n_fail = 0;
  int          checks = 0;
  int          cyc = 0;
  always #12.5 clk_sys = ~clk_sys;
  frc_cpu_model u_cpu (.clk_sys(clk_sys), .nrst(nrst), .hot(hot), .temp_set(temp_set),
    .thermal_alert_n(thermal_alert_n), .cur_temp(cur_temp));
  frc_fan_ramp #(.TICK_CYCLES(TK)) DUT (.clk_sys(clk_sys), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .thermal_alert_n(thermal_alert_n),
    .cur_temp(cur_temp), .adj_start_temp(adj_start_temp), .adj_start_valid(adj_start_valid),
    .duty_target(duty_target), .duty_out(duty_out), .fan_start_temp(fan_start_temp),
    .op_point(op_point), .dyn_floor_en(dyn_floor_en));
  task automatic complete_run();
    $display("checks %0d n_fail %0d", checks, n_fail);
    if (n_fail == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 5000) begin
      n_fail++;
      complete_run();
    end
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e) begin
      n_fail++;
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic apb(input logic w, input logic [7:0] ix, input logic [31:0] wd,
                     output logic [31:0] rd, output logic er);
    @(posedge clk_sys);
    psel    <= 1'b1;
    pwrite  <= w;
    paddr   <= {2'h0, ix, 2'h0};
    pwdata  <= wd;
    @(posedge clk_sys);
    penable <= 1'b1;
    @(posedge clk_sys);
    while (pready !== 1'b1) @(posedge clk_sys);
    rd      = prdata;
    er      = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] ix, input logic [7:0] d);
    logic [31:0] r;
    logic        e;
    apb(1'b1, ix, {24'h00_0000, d}, r, e);
  endtask
  task automatic wchg(input int ch, output int n);
    logic [7:0] v;
    v = duty_out[8*ch +: 8];
    n = 0;
    while (duty_out[8*ch +: 8] === v && n < 400) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
  endtask
  task automatic t_regs();
    logic [7:0]  ix[6] = '{IDX_DYN_CTRL, IDX_OUT1_CFG, IDX_OUT2_CFG, IDX_OUT3_CFG,
                           IDX_RAMP_1, IDX_RAMP_2};
    logic [31:0] r;
    logic        e;
    for (int i = 0; i < 6; i++) begin
      apb(1'b0, ix[i], 32'h0000_0000, r, e);
      chk("reset value", 32'h0000_0000, r);
      wr(ix[i], 8'ha5 ^ 8'(i));
      apb(1'b0, ix[i], 32'h0000_0000, r, e);
      chk("readback", {24'h00_0000, 8'ha5 ^ 8'(i)}, r);
      wr(ix[i], 8'h00);
    end
    apb(1'b0, 8'h01, 32'h0000_0000, r, e);
    chk("unmapped err", 32'h0000_0001, {31'h0, e});
    chk("unmapped data", 32'h0000_0000, r);
  endtask
  task automatic t_pass();
    @(posedge clk_sys);
    duty_target <= 24'h3c_c35a;
    repeat (2) @(posedge clk_sys);
    #1;
    chk("passthrough", 32'h003c_c35a, {8'h00, duty_out});
  endtask
  task automatic pulse_hot();
    @(posedge clk_sys);
    hot <= 1'b1;
    repeat (4) @(posedge clk_sys);
    hot <= 1'b0;
    repeat (4) @(posedge clk_sys);
    #1;
  endtask
  task automatic t_cap();
    wr(IDX_DYN_CTRL, 8'h08);
    temp_set <= 24'h33_4455;
    pulse_hot();
    chk("op local", {8'h00, 24'h00_4400}, {8'h00, op_point});
    wr(IDX_DYN_CTRL, 8'h14);
    temp_set <= 24'h66_7788;
    pulse_hot();
    chk("op remote", {8'h00, 24'h66_4488}, {8'h00, op_point});
  endtask
  task automatic pulse_adj(input logic [7:0] d, input logic [2:0] en, input logic [23:0] e);
    wr(IDX_DYN_CTRL, d);
    adj_start_temp  <= 24'h11_2233;
    adj_start_valid <= 1'b1;
    @(posedge clk_sys);
    adj_start_valid <= 1'b0;
    @(posedge clk_sys);
    #1;
    chk("dyn enable", {29'h0, en}, {29'h0, dyn_floor_en});
    chk("fan start", {8'h00, e}, {8'h00, fan_start_temp});
  endtask
  task automatic set1(input logic [7:0] v);
    @(posedge clk_sys);
    duty_target.out1 <= v;
  endtask
  task automatic t_ramp();
    int st[8] = '{1, 2, 3, 5, 8, 12, 24, 48};
    int n;
    for (int c = 0; c < 8; c++) begin
      wr(IDX_RAMP_1, 8'h00);
      set1(8'h00);
      repeat (3) @(posedge clk_sys);
      wr(IDX_RAMP_1, 8'h08 | 8'(c));
      set1(8'h64);
      wchg(0, n);
      chk("step out1", 32'(st[c]), {24'h0, duty_out.out1});
    end
    set1(8'h63);
    wchg(0, n);
    chk("ramp on", 32'h0000_0060, {24'h0, duty_out.out1});
    wchg(0, n);
    chk("land", 32'h0000_0063, {24'h0, duty_out.out1});
    set1(8'h32);
    wchg(0, n);
    chk("ramp down", 32'h0000_0033, {24'h0, duty_out.out1});
    @(posedge clk_sys);
    duty_target.out2 <= 8'h00;
    duty_target.out3 <= 8'h00;
    repeat (3) @(posedge clk_sys);
    wr(IDX_RAMP_2, 8'hb9);
    @(posedge clk_sys);
    duty_target.out2 <= 8'h64;
    duty_target.out3 <= 8'h64;
    wchg(1, n);
    chk("step out2", 32'h0000_0005, {24'h0, duty_out.out2});
    chk("step out3", 32'h0000_0002, {24'h0, duty_out.out3});
  endtask
  task automatic t_slow();
    int n;
    wr(IDX_RAMP_1, 8'h00);
    set1(8'h00);
    repeat (3) @(posedge clk_sys);
    wr(IDX_OUT1_CFG, 8'h08);
    wr(IDX_RAMP_1, 8'h08);
    set1(8'hff);
    wchg(0, n);
    wchg(0, n);
    chk("slow gap", 32'(4 * TK), 32'(n));
    chk("slow step", 32'h0000_0002, {24'h0, duty_out.out1});
  endtask
  initial begin
    repeat (16) @(posedge clk_sys);
    nrst <= 1'b1;
    t_regs();
    t_pass();
    t_cap();
    pulse_adj(8'h40, 3'b010, 24'h00_2200);
    pulse_adj(8'ha0, 3'b101, 24'h11_2233);
    t_ramp();
    t_slow();
    complete_run();
  end
endmodule // tb_fan_ramp_and_setpoint_capture
